// File: logic/lc_consts.svh
//////////////////////////////////////////////////////////////////////
// Purpose: offsets, field positions, reset values of the setting bank
// Assumes: byte-wide registers at their printed byte offsets
// Notes: included by every design file that decodes the bank
//////////////////////////////////////////////////////////////////////
`ifndef LC_CONSTS_SVH
`define LC_CONSTS_SVH

// byte offsets
`define LC_ADDR_ALT_MULT_HI 8'h1c
`define LC_ADDR_ALT_MULT_LO 8'h1d
`define LC_ADDR_ALT_REF_LO 8'h1e
`define LC_ADDR_ALT_Q_LO 8'h1f
`define LC_ADDR_SPREAD_A 8'h20
`define LC_ADDR_SPREAD_B 8'h21
`define LC_ADDR_SPREAD_C 8'h22
`define LC_ADDR_FREQ_SET 8'h23
`define LC_ADDR_ROUTING 8'h24
`define LC_ADDR_STATE_SEL 8'h25
`define LC_ADDR_TYPE_DIV4 8'h26
`define LC_ADDR_DIV5 8'h27
`define LC_NUM_BYTES 12

// byte index of each register, counted from the first offset
`define LC_IDX_ALT_MULT_HI 4'h0
`define LC_IDX_ALT_MULT_LO 4'h1
`define LC_IDX_ALT_REF_LO 4'h2
`define LC_IDX_ALT_Q_LO 4'h3
`define LC_IDX_SPREAD_A 4'h4
`define LC_IDX_SPREAD_B 4'h5
`define LC_IDX_SPREAD_C 4'h6
`define LC_IDX_FREQ_SET 4'h7
`define LC_IDX_ROUTING 4'h8
`define LC_IDX_STATE_SEL 4'h9
`define LC_IDX_TYPE_DIV4 4'ha
`define LC_IDX_DIV5 4'hb

// reset values
`define LC_RST_ALT_MULT_HI 8'h00
`define LC_RST_ALT_MULT_LO 8'h40
`define LC_RST_ALT_REF_LO 8'h02
`define LC_RST_ALT_Q_LO 8'h08
`define LC_RST_SPREAD 8'h00
`define LC_RST_FREQ_SET 8'h00
`define LC_RST_ROUTING 8'hed
`define LC_RST_STATE_SEL 8'h02
`define LC_RST_TYPE_DIV4 8'h01
`define LC_RST_DIV5 8'h01

// field positions
`define LC_BYPASS_BIT 7
`define LC_OUT4_SRC_BIT 6
`define LC_OUT5_SRC_MSB 5
`define LC_OUT5_SRC_LSB 4
`define LC_STATE_ONE_MSB 3
`define LC_STATE_ONE_LSB 2
`define LC_STATE_ZERO_MSB 1
`define LC_STATE_ZERO_LSB 0
`define LC_SPREAD_TYPE_BIT 7
`define LC_DIV_MSB 6
`define LC_RSVD_BIT 7
`define LC_SPREAD_W 3

// written bits kept; the reserved top bit of the divider-5 byte is dropped
`define LC_MASK_ALL 8'hff
`define LC_MASK_DIV5 8'h7f

// spread depth, in quarter percent, of the largest code
`define LC_DEPTH_TOP 4'h8
`define LC_DIV_STANDBY 7'h00

`endif

// File: logic/lc_pkg.sv
//////////////////////////////////////////////////////////////////////
// Purpose: types shared by the setting bank and its helpers
// Assumes: nothing beyond the constants header
// Notes: enum order follows the two-bit field codes
//////////////////////////////////////////////////////////////////////
package lc_pkg;

   typedef enum logic [1:0] {
      LC_OFF_POWER_DOWN,
      LC_TRISTATE,
      LC_DRIVE_LOW,
      LC_ENABLED
   } lc_out_state_t;

   typedef enum logic [1:0] {
      LC_SRC5_DIV2,
      LC_SRC5_DIV4,
      LC_SRC5_DIV5,
      LC_SRC5_RESERVED
   } lc_out5_src_t;

   typedef struct packed {
      logic [2:0] spread_amount;
      logic [3:0] spread_depth_qpct;
      logic spread_centre;
      logic freq_set_second;
      logic bypass;
      logic power_down;
   } lc_loop2_ctl_t;

   typedef struct packed {
      logic out4_src_div4;
      lc_out5_src_t out5_src;
      lc_out_state_t out45_state;
      logic [6:0] fourth_output_divider;
      logic [6:0] fifth_output_divider;
      logic div4_standby;
      logic div5_standby;
   } lc_out_ctl_t;

   typedef struct packed {
      logic [11:0] multiplier;
      logic [8:0] ref_term;
      logic [5:0] q_term;
      logic [2:0] p_term;
      logic [1:0] osc_band;
   } lc_loop1_alt_t;

endpackage

// File: logic/lc_reg_bank.sv
//////////////////////////////////////////////////////////////////////
// Purpose: loop-2 setting register bank with the loop-1 alternate tail
// Assumes: select pins asynchronous; byte registers at printed offsets
// Notes: outputs follow the setting chosen by the select pins
//
// Notes on behaviour
// - spread code 000 off, others 0.25 to 2.0%
// - eight settings; select pins pick active one
// - frequency bit 0 first set, 1 second
// - bypass bit 1 bypasses, powers loop down
// - out4 source: 0 divider two, 1 four
// - out5 source 00/01/10 dividers, 11 reserved
// - state codes: powerdown, tristate, low, enabled
// - state bit picks definition zero or one
// - spread type 0 down, 1 centre
// - divider four: 0 standby, else ratio
// - divider five: 0 standby, else ratio
// - bytes move most significant bit first
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "lc_consts.svh"

module lc_reg_bank
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output var logic [7:0] rd_data,
   input wire logic setting_select_pin_a,
   input wire logic setting_select_pin_b,
   input wire logic setting_select_pin_c,
   output var logic [2:0] active_setting,
   output var lc_pkg::lc_loop2_ctl_t loop2_ctl,
   output var lc_pkg::lc_out_ctl_t out_ctl,
   output var lc_pkg::lc_loop1_alt_t loop1_alt
);

   //////////////////////////////////////////////////////////////////
   // decoding helpers

   function automatic logic lc_hit(input logic [7:0] a);
      return (a >= `LC_ADDR_ALT_MULT_HI) && (a <= `LC_ADDR_DIV5);
   endfunction

   function automatic logic [3:0] lc_index(input logic [7:0] a);
      logic [7:0] diff;
      diff = a - `LC_ADDR_ALT_MULT_HI;
      return diff[3:0];
   endfunction

   function automatic logic [7:0] lc_reset_value(input logic [3:0] i);
      logic [7:0] v;
      v = `LC_RST_SPREAD;
      unique case (i)
         `LC_IDX_ALT_MULT_HI: v = `LC_RST_ALT_MULT_HI;
         `LC_IDX_ALT_MULT_LO: v = `LC_RST_ALT_MULT_LO;
         `LC_IDX_ALT_REF_LO: v = `LC_RST_ALT_REF_LO;
         `LC_IDX_ALT_Q_LO: v = `LC_RST_ALT_Q_LO;
         `LC_IDX_FREQ_SET: v = `LC_RST_FREQ_SET;
         `LC_IDX_ROUTING: v = `LC_RST_ROUTING;
         `LC_IDX_STATE_SEL: v = `LC_RST_STATE_SEL;
         `LC_IDX_TYPE_DIV4: v = `LC_RST_TYPE_DIV4;
         `LC_IDX_DIV5: v = `LC_RST_DIV5;
         default: v = `LC_RST_SPREAD;
      endcase
      return v;
   endfunction

   // reserved top bit of divider five never stored, reads as zero
   function automatic logic [7:0] lc_write_mask(input logic [3:0] i);
      logic [7:0] m;
      m = `LC_MASK_ALL;
      if (i == `LC_IDX_DIV5)
      begin
         m = `LC_MASK_DIV5;
      end
      return m;
   endfunction

   // depth in quarter percent; top code jumps to 2.0 rather than 1.75
   function automatic logic [3:0] lc_depth(input logic [2:0] code);
      logic [3:0] d;
      d = {1'b0, code};
      if (code == 3'h7)
      begin
         d = `LC_DEPTH_TOP;
      end
      return d;
   endfunction

   function automatic logic lc_standby(input logic [6:0] div);
      return div == `LC_DIV_STANDBY;
   endfunction

   //////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] bank [`LC_NUM_BYTES];
   logic wr_hit;
   logic [3:0] wr_idx;

   assign wr_hit = wr_strobe && lc_hit(addr);
   assign wr_idx = lc_index(addr);

   // writes outside the map are dropped, so stray high offsets harmless
   for (genvar i = 0; i < `LC_NUM_BYTES; i++)
   begin : g_byte
      always_ff @(posedge core_clk or posedge reset)
      begin
         if (reset)
         begin
            bank[i] <= lc_reset_value(4'(i));
         end
         else if (wr_hit && (wr_idx == 4'(i)))
         begin
            bank[i] <= wr_data & lc_write_mask(4'(i));
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // read port: data stand in the cycle after the strobe only

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         rd_data <= 8'h00;
      end
      else if (rd_strobe && lc_hit(addr))
      begin
         // bit 7 is the first bit on the serial wire
         rd_data <= bank[lc_index(addr)];
      end
      else
      begin
         rd_data <= 8'h00;
      end
   end

   //////////////////////////////////////////////////////////////////
   // setting index from the select pins

   logic [2:0] pins_sync;

   lc_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in({setting_select_pin_c, setting_select_pin_b,
                 setting_select_pin_a}),
      .sync_out(pins_sync)
   );

   logic pick_freq;
   logic pick_state;
   logic [2:0] pick_amount;

   // pin c is the most significant index bit
   lc_setting_pick u_pick (
      .index(pins_sync),
      .freq_bits(bank[`LC_IDX_FREQ_SET]),
      .state_bits(bank[`LC_IDX_STATE_SEL]),
      .amounts({bank[`LC_IDX_SPREAD_A], bank[`LC_IDX_SPREAD_B],
                bank[`LC_IDX_SPREAD_C]}),
      .freq_bit(pick_freq),
      .state_bit(pick_state),
      .amount(pick_amount)
   );

   //////////////////////////////////////////////////////////////////
   // field extraction

   logic [7:0] routing;
   logic [7:0] type_div4;
   logic [1:0] state_zero;
   logic [1:0] state_one;
   logic [1:0] state_code;
   logic bypass;

   assign routing = bank[`LC_IDX_ROUTING];
   assign type_div4 = bank[`LC_IDX_TYPE_DIV4];
   assign state_zero = routing[`LC_STATE_ZERO_MSB:`LC_STATE_ZERO_LSB];
   assign state_one = routing[`LC_STATE_ONE_MSB:`LC_STATE_ONE_LSB];
   assign state_code = pick_state ? state_one : state_zero;
   assign bypass = routing[`LC_BYPASS_BIT];

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         active_setting <= 3'h0;
      end
      else
      begin
         active_setting <= pins_sync;
      end
   end

   //////////////////////////////////////////////////////////////////
   // loop-2 control, one cycle behind the index

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         loop2_ctl <= '0;
      end
      else
      begin
         loop2_ctl.spread_amount <= pick_amount;
         loop2_ctl.spread_depth_qpct <= lc_depth(pick_amount);
         loop2_ctl.spread_centre <= type_div4[`LC_SPREAD_TYPE_BIT];
         loop2_ctl.freq_set_second <= pick_freq;
         loop2_ctl.bypass <= bypass;
         // either bypass or state code 00 shuts the loop
         loop2_ctl.power_down <= bypass || (state_code == 2'h0);
      end
   end

   //////////////////////////////////////////////////////////////////
   // output routing, state and dividers

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         out_ctl <= '0;
      end
      else
      begin
         out_ctl.out4_src_div4 <= routing[`LC_OUT4_SRC_BIT];
         // reserved code passed on as is; the output stage ignores it
         out_ctl.out5_src <= lc_pkg::lc_out5_src_t'(
            routing[`LC_OUT5_SRC_MSB:`LC_OUT5_SRC_LSB]);
         out_ctl.out45_state <= lc_pkg::lc_out_state_t'(state_code);
         out_ctl.fourth_output_divider <=
            type_div4[`LC_DIV_MSB:0];
         out_ctl.fifth_output_divider <=
            bank[`LC_IDX_DIV5][`LC_DIV_MSB:0];
         out_ctl.div4_standby <=
            lc_standby(type_div4[`LC_DIV_MSB:0]);
         out_ctl.div5_standby <=
            lc_standby(bank[`LC_IDX_DIV5][`LC_DIV_MSB:0]);
      end
   end

   //////////////////////////////////////////////////////////////////
   // loop-1 alternate terms; limits are the host's to keep

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         loop1_alt <= '0;
      end
      else
      begin
         loop1_alt.multiplier <= {bank[`LC_IDX_ALT_MULT_HI],
                                  bank[`LC_IDX_ALT_MULT_LO][7:4]};
         loop1_alt.ref_term <= {bank[`LC_IDX_ALT_MULT_LO][3:0],
                                bank[`LC_IDX_ALT_REF_LO][7:3]};
         loop1_alt.q_term <= {bank[`LC_IDX_ALT_REF_LO][2:0],
                              bank[`LC_IDX_ALT_Q_LO][7:5]};
         loop1_alt.p_term <= bank[`LC_IDX_ALT_Q_LO][4:2];
         loop1_alt.osc_band <= bank[`LC_IDX_ALT_Q_LO][1:0];
      end
   end

endmodule

`default_nettype wire

// File: logic/lc_setting_pick.sv
//////////////////////////////////////////////////////////////////////
// Purpose: picks setting x out of the per-setting registers
// Assumes: index already synchronised
// Notes: purely combinational; the caller registers the result
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "lc_consts.svh"

module lc_setting_pick
(
   input wire logic [2:0] index,
   input wire logic [7:0] freq_bits,
   input wire logic [7:0] state_bits,
   input wire logic [23:0] amounts,
   output logic freq_bit,
   output logic state_bit,
   output logic [2:0] amount
);

   logic [2:0] amount_of [8];

   // field x sits at bits 3x+2..3x of the three spread bytes
   for (genvar x = 0; x < 8; x++)
   begin : g_amt
      assign amount_of[x] = amounts[`LC_SPREAD_W*x +: `LC_SPREAD_W];
   end

   assign freq_bit = freq_bits[index];
   assign state_bit = state_bits[index];
   assign amount = amount_of[index];

endmodule

`default_nettype wire

// File: logic/lc_sync.sv
//////////////////////////////////////////////////////////////////////
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: pins change slowly against core_clk
// Notes: first stage feeds only the second
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

module lc_sync
#(
   parameter int WIDTH = 3
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output var logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         meta <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

// File: tb/lc_host_model.sv
// Purpose: programming host and select pin driver
// Assumes: one-cycle strobes, no wait states
// Notes: idle bus lines show inverted data, not the last value
`timescale 1ns/1ps
`default_nettype none

module lc_host_model
(
   input wire logic core_clk,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   output logic rd_strobe,
   output logic [2:0] pins
);
   initial
   begin
      addr = 8'h00;
      wr_data = 8'h00;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      pins = 3'h0;
   end
   //////////////////////////////
   // callers stay below 0x40
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= (a == 8'h27) ? (d & 8'h7f) : d;
      wr_strobe <= 1'b1;
      @(posedge core_clk);
      wr_strobe <= 1'b0;
      addr <= ~a;
      wr_data <= ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge core_clk);
      rd_strobe <= 1'b0;
      addr <= ~a;
   endtask
   task automatic pick(input logic [2:0] i);
      @(posedge core_clk);
      pins <= i;
   endtask
endmodule

`default_nettype wire

// File: tb/lc_reg_bank_monitor.sv
// Purpose: port checker for the setting bank
// Assumes: outputs lag a stored write by one edge
// Notes: bound to every lc_reg_bank
`timescale 1ns/1ps
`default_nettype none

module lc_reg_bank_monitor
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] rd_data,
   input wire logic setting_select_pin_a,
   input wire logic setting_select_pin_b,
   input wire logic setting_select_pin_c,
   input wire logic [2:0] active_setting,
   input wire lc_pkg::lc_loop2_ctl_t loop2_ctl,
   input wire lc_pkg::lc_out_ctl_t out_ctl
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic [2:0] pins;
   assign pins = {setting_select_pin_c, setting_select_pin_b,
      setting_select_pin_a};
   // a second write to the same byte would mask the first
   sequence s_lone_wr(a);
      wr_strobe && addr == a ##1 !(wr_strobe && addr == a);
   endsequence
   //////////////////////////////
   a_power_down_cause: assert property (
      !$past(reset) |-> loop2_ctl.power_down == (loop2_ctl.bypass ||
      out_ctl.out45_state == lc_pkg::LC_OFF_POWER_DOWN))
      else $error("power down not from bypass or state");
   a_div4_standby: assert property (
      !$past(reset) |-> out_ctl.div4_standby ==
      (out_ctl.fourth_output_divider == 7'h00))
      else $error("divider four standby wrong");
   a_div5_standby: assert property (
      !$past(reset) |-> out_ctl.div5_standby ==
      (out_ctl.fifth_output_divider == 7'h00))
      else $error("divider five standby wrong");
   a_spread_depth: assert property (
      !$past(reset) |-> loop2_ctl.spread_depth_qpct ==
      (loop2_ctl.spread_amount == 3'h7 ? 4'h8 :
      {1'b0, loop2_ctl.spread_amount}))
      else $error("spread depth wrong");
   a_rsvd_reads_zero: assert property (
      rd_strobe && addr == 8'h27 |=> rd_data[7] == 1'b0)
      else $error("reserved bit read as one");
   a_route_write_path: assert property (
      s_lone_wr(8'h24) |=> loop2_ctl.bypass == $past(wr_data[7], 2) &&
      out_ctl.out4_src_div4 == $past(wr_data[6], 2) &&
      out_ctl.out5_src == $past(wr_data[5:4], 2))
      else $error("routing byte not applied");
   a_div4_write_path: assert property (
      s_lone_wr(8'h26) |=> loop2_ctl.spread_centre == $past(wr_data[7], 2)
      && out_ctl.fourth_output_divider == $past(wr_data[6:0], 2))
      else $error("type and divider byte not applied");
   a_index_follows_pins: assert property (
      $stable(pins) [*3] |=> active_setting == $past(pins))
      else $error("active setting not the pin index");
endmodule

bind lc_reg_bank lc_reg_bank_monitor mon
(
   .core_clk(core_clk),
   .reset(reset),
   .addr(addr),
   .wr_data(wr_data),
   .wr_strobe(wr_strobe),
   .rd_strobe(rd_strobe),
   .rd_data(rd_data),
   .setting_select_pin_a(setting_select_pin_a),
   .setting_select_pin_b(setting_select_pin_b),
   .setting_select_pin_c(setting_select_pin_c),
   .active_setting(active_setting),
   .loop2_ctl(loop2_ctl),
   .out_ctl(out_ctl)
);

`default_nettype wire

// File: tb/test_lc_reg_bank.sv
// Purpose: self-checking bench of the setting bank
// Assumes: four edges cover pin sync and write lag
// Notes: reads checked from a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none

module test_lc_reg_bank;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr, wr_data, rd_data, fs, st, r;
   logic wr_strobe, rd_strobe;
   logic [2:0] pins, active_setting;
   lc_pkg::lc_loop2_ctl_t loop2_ctl;
   lc_pkg::lc_out_ctl_t out_ctl;
   lc_pkg::lc_loop1_alt_t loop1_alt;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   logic [23:0] amt;
   logic [7:0] rv [12] = '{8'h00, 8'h40, 8'h02, 8'h08, 8'h00, 8'h00,
      8'h00, 8'h00, 8'hed, 8'h02, 8'h01, 8'h01};
   int n_mismatch = 0;
   int samples_checked = 0;
   always #25 core_clk = ~core_clk;
   lc_host_model host (.core_clk(core_clk), .addr(addr),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .pins(pins));
   lc_reg_bank dut (.core_clk(core_clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .rd_data(rd_data), .setting_select_pin_a(pins[0]),
      .setting_select_pin_b(pins[1]), .setting_select_pin_c(pins[2]),
      .active_setting(active_setting), .loop2_ctl(loop2_ctl),
      .out_ctl(out_ctl), .loop1_alt(loop1_alt));
   //////////////////////////////
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task automatic settle();
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge core_clk)
   begin
      if (rd_seen)
         chk(24'(rd_data), 24'(exp_q.pop_front()));
      rd_seen <= rd_strobe;
   end
   //////////////////////////////
   initial
   begin
      void'($urandom(32'h3a9e_fd7b));
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 12; i++)
         rd_exp(8'h1c + 8'(i), rv[i]);
      host.wr(8'h30, 8'h5a);
      rd_exp(8'h30, 8'h00);
      settle();
      chk(24'({loop2_ctl.bypass, out_ctl.out4_src_div4, out_ctl.out5_src,
         out_ctl.fourth_output_divider, out_ctl.fifth_output_divider}),
         24'({1'b1, 1'b1, 2'b10, 7'h01, 7'h01}));
      chk(24'({loop1_alt.ref_term, loop1_alt.q_term, loop1_alt.p_term,
         loop1_alt.osc_band}), 24'({9'h000, 6'h10, 3'h2, 2'h0}));
      $display("reset test done");
      fs = 8'($urandom);
      st = 8'($urandom);
      amt = 24'($urandom);
      host.wr(8'h20, amt[23:16]);
      host.wr(8'h21, amt[15:8]);
      host.wr(8'h22, amt[7:0]);
      host.wr(8'h23, fs);
      host.wr(8'h25, st);
      for (int i = 0; i < 8; i++)
      begin
         host.pick(3'(i));
         settle();
         chk(24'({loop2_ctl.freq_set_second, loop2_ctl.spread_amount,
            out_ctl.out45_state, active_setting}), 24'({fs[i],
            amt[3*i+:3], (st[i] ? 2'b11 : 2'b01), 3'(i)}));
         chk(24'(loop2_ctl.spread_depth_qpct),
            24'((amt[3*i+:3] == 3'h7) ? 4'h8 : {1'b0, amt[3*i+:3]}));
      end
      $display("setting test done");
      for (int j = 0; j < 4; j++)
      begin
         r = {1'b0, j[0], 2'(j), 2'(j), 2'(j)};
         host.wr(8'h24, r);
         settle();
         chk(24'({loop2_ctl.bypass, loop2_ctl.power_down,
            out_ctl.out4_src_div4, out_ctl.out5_src, out_ctl.out45_state}),
            24'({1'b0, j == 0, r[6], 2'(j), 2'(j)}));
      end
      host.wr(8'h24, 8'h8f);
      settle();
      chk(24'({loop2_ctl.bypass, loop2_ctl.power_down}), 24'h00_0003);
      $display("routing test done");
      r = 8'($urandom) | 8'h01;
      host.wr(8'h1c, r);
      host.wr(8'h26, 8'h80);
      host.wr(8'h27, 8'hff);
      settle();
      chk(24'({loop2_ctl.spread_centre, out_ctl.div4_standby,
         out_ctl.fourth_output_divider, out_ctl.div5_standby,
         out_ctl.fifth_output_divider}),
         24'({1'b1, 1'b1, 7'h00, 1'b0, 7'h7f}));
      chk(24'(loop1_alt.multiplier), 24'({r, 4'h4}));
      host.wr(8'h26, 8'h05);
      host.wr(8'h27, 8'h00);
      rd_exp(8'h26, 8'h05);
      settle();
      chk(24'({loop2_ctl.spread_centre, out_ctl.div4_standby,
         out_ctl.fourth_output_divider, out_ctl.div5_standby}),
         24'({1'b0, 1'b0, 7'h05, 1'b1}));
      $display("divider test done");
      end_sim();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      n_mismatch++;
      end_sim();
   end
endmodule

`default_nettype wire
